/* rtl/fci_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fci_cfg.svh"

// Summary of operation
// - write: select and strobe low, edges latch
// - erase needs two erase-code writes
// - erase check write carries target address
// - program set-up then address/data write
// - program check write, then read margin byte
// - reset is two all-ones writes
// - host keeps pulses at least minimum
module fci_host #(
  parameter int PROG_PULSE_US = `FCI_PROG_PULSE_US,
  parameter int ERASE_PULSE_US = `FCI_ERASE_PULSE_US
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // user request
  input wire logic req_valid,
  input wire fci_pkg::fci_req_s req,
  output logic req_ready,
  input wire logic supply_request,
  // user answer
  output logic rsp_valid,
  output logic [`FCI_DATA_W-1:0] rsp_data,
  output logic rsp_error,
  // memory pins
  output fci_pkg::fci_pins_s pins,
  output logic [`FCI_DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [`FCI_DATA_W-1:0] data_in
);

  // ----------------------------------------------------------------------
  // cycle counts of the minimum pulses (rounded up)
  // ----------------------------------------------------------------------
  localparam int PROG_CYC = (PROG_PULSE_US * 1000 + `FCI_CLK_NS - 1) / `FCI_CLK_NS;
  localparam int ERASE_CYC = (ERASE_PULSE_US * 1000 + `FCI_CLK_NS - 1) / `FCI_CLK_NS;

  fci_pkg::fci_state_e state; // controller state
  fci_pkg::fci_state_e next_state;
  fci_pkg::fci_req_s cur; // request in progress
  logic [2:0] idx; // step index
  logic [31:0] cnt; // cycles in current state
  logic err; // write refused for low supply
  logic [`FCI_DATA_W-1:0] last_wr; // last byte written
  logic [`FCI_DATA_W-1:0] prev_wr; // byte before that
  logic [`FCI_DATA_W-1:0] sync_data;
  logic sync_stable;

  // ----------------------------------------------------------------------
  // sequence tables
  // ----------------------------------------------------------------------
  function automatic fci_pkg::fci_step_s mk(input fci_pkg::fci_act_e a,
      input logic [`FCI_DATA_W-1:0] d, input logic ua, input logic ud);
    fci_pkg::fci_step_s s;
    s.act = a;
    s.data = d;
    s.use_addr = ua;
    s.use_data = ud;
    return s;
  endfunction

  function automatic fci_pkg::fci_step_s step_of(input fci_pkg::fci_op_e op,
      input logic [2:0] i);
    fci_pkg::fci_step_s s;
    s = mk(fci_pkg::ACT_NONE, `FCI_CMD_READ, 1'b0, 1'b0);
    case (op)
      // plain array or pin-identifier read
      fci_pkg::OP_READ, fci_pkg::OP_ID_PIN:
        if (i == 3'h0) s = mk(fci_pkg::ACT_RD, `FCI_CMD_READ, 1'b1, 1'b0);
      // single command write, always at address zero
      fci_pkg::OP_CMD:
        if (i == 3'h0) s = mk(fci_pkg::ACT_WR, `FCI_CMD_READ, 1'b0, 1'b1);
      // erase: two codes, pulse, check with address, read
      fci_pkg::OP_ERASE:
        case (i)
          3'h0, 3'h1: s = mk(fci_pkg::ACT_WR, `FCI_CMD_ERASE, 1'b0, 1'b0);
          3'h2: s = mk(fci_pkg::ACT_ERASE_WAIT, `FCI_CMD_READ, 1'b0, 1'b0);
          3'h3: s = mk(fci_pkg::ACT_WR, `FCI_CMD_ERASE_CHECK, 1'b1, 1'b0);
          3'h4: s = mk(fci_pkg::ACT_RD, `FCI_CMD_READ, 1'b1, 1'b0);
          default: s = mk(fci_pkg::ACT_NONE, `FCI_CMD_READ, 1'b0, 1'b0);
        endcase
      // program: set-up, address/data, pulse, check, read
      fci_pkg::OP_PROGRAM:
        case (i)
          3'h0: s = mk(fci_pkg::ACT_WR, `FCI_CMD_PROGRAM, 1'b0, 1'b0);
          3'h1: s = mk(fci_pkg::ACT_WR, `FCI_CMD_READ, 1'b1, 1'b1);
          3'h2: s = mk(fci_pkg::ACT_PROG_WAIT, `FCI_CMD_READ, 1'b0, 1'b0);
          3'h3: s = mk(fci_pkg::ACT_WR, `FCI_CMD_PROGRAM_CHECK, 1'b0, 1'b0);
          3'h4: s = mk(fci_pkg::ACT_RD, `FCI_CMD_READ, 1'b1, 1'b0);
          default: s = mk(fci_pkg::ACT_NONE, `FCI_CMD_READ, 1'b0, 1'b0);
        endcase
      // reset: two all-ones writes
      fci_pkg::OP_RESET:
        if (i <= 3'h1) s = mk(fci_pkg::ACT_WR, `FCI_CMD_RESET, 1'b0, 1'b0);
      default: s = mk(fci_pkg::ACT_NONE, `FCI_CMD_READ, 1'b0, 1'b0);
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  wire fci_pkg::fci_step_s step = step_of(cur.op, idx);
  wire fci_pkg::fci_step_s nstep = step_of(cur.op, idx + 3'h1);
  wire is_wr = (step.act == fci_pkg::ACT_WR);
  wire is_rd = (step.act == fci_pkg::ACT_RD);
  wire [`FCI_DATA_W-1:0] wr_byte = step.use_data ? cur.data : step.data;
  wire [`FCI_ADDR_W-1:0] wr_addr = step.use_addr ? cur.addr : '0;
  wire needs_wr = (req.op != fci_pkg::OP_READ) && (req.op != fci_pkg::OP_ID_PIN);
  wire [31:0] pulse_need = (step.act == fci_pkg::ACT_ERASE_WAIT) ? 32'(ERASE_CYC)
                                                                  : 32'(PROG_CYC);
  wire setup_done = (cnt >= 32'(`FCI_SETUP_CYC - 1));
  wire wr_done = (cnt >= 32'(`FCI_WE_CYC - 1));
  wire rd_done = (cnt >= 32'(`FCI_ACCESS_CYC + `FCI_SYNC_CYC - 1)) && sync_stable;
  wire rec_done = (cnt >= 32'(`FCI_RECOVER_CYC - 1));
  wire pulse_done = (cnt >= pulse_need - 32'd1);
  wire step_last = (nstep.act == fci_pkg::ACT_NONE);
  wire in_cycle = (state == fci_pkg::ST_SETUP) || (state == fci_pkg::ST_STROBE)
                  || (state == fci_pkg::ST_HOLD);

  assign req_ready = (state == fci_pkg::ST_IDLE);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      fci_pkg::ST_IDLE:
        if (req_valid)
          next_state = (needs_wr && !pins.supply_high) ? fci_pkg::ST_FINISH
                                                       : fci_pkg::ST_SETUP;
      fci_pkg::ST_SETUP:
        if (is_wr && !pins.supply_high)
          next_state = fci_pkg::ST_FINISH;
        else if (setup_done)
          next_state = fci_pkg::ST_STROBE;
      fci_pkg::ST_STROBE:
        if ((is_wr && wr_done) || (is_rd && rd_done))
          next_state = fci_pkg::ST_HOLD;
      fci_pkg::ST_HOLD:
        next_state = fci_pkg::ST_RECOVER;
      fci_pkg::ST_RECOVER:
        if (rec_done)
          next_state = step_last ? fci_pkg::ST_FINISH
                     : (nstep.act == fci_pkg::ACT_WR || nstep.act == fci_pkg::ACT_RD)
                       ? fci_pkg::ST_SETUP : fci_pkg::ST_PULSE;
      fci_pkg::ST_PULSE:
        if (pulse_done)
          next_state = fci_pkg::ST_SETUP;
      fci_pkg::ST_FINISH:
        next_state = fci_pkg::ST_IDLE;
      default:
        next_state = fci_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= fci_pkg::ST_IDLE;
      cur <= '0;
      idx <= 3'h0;
      cnt <= '0;
      err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? 32'd0 : cnt + 32'd1;
      if (state == fci_pkg::ST_IDLE && req_valid)
      begin
        cur <= req;
        idx <= 3'h0;
        err <= (next_state == fci_pkg::ST_FINISH);
      end
      else if (state == fci_pkg::ST_SETUP && next_state == fci_pkg::ST_FINISH)
        err <= 1'b1;
      else if ((state == fci_pkg::ST_RECOVER && rec_done && !step_last)
               || (state == fci_pkg::ST_PULSE && pulse_done))
        idx <= idx + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // history of written bytes, and answer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_wr <= `FCI_CMD_READ;
      prev_wr <= `FCI_CMD_READ;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_error <= 1'b0;
    end
    else
    begin
      if (state == fci_pkg::ST_HOLD && is_wr)
      begin
        last_wr <= wr_byte;
        prev_wr <= last_wr;
      end
      // read byte is taken as the strobe ends
      if (state == fci_pkg::ST_STROBE && is_rd && rd_done)
        rsp_data <= sync_data;
      rsp_valid <= (state == fci_pkg::ST_FINISH);
      rsp_error <= (state == fci_pkg::ST_FINISH) && err;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers, registered from state and supply_request
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pins <= '{supply_high: 1'b0, id_hv: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                we_n: 1'b1, addr: '0};
      data_out <= '0;
      data_oe_n <= 1'b1;
    end
    else
    begin
      pins.supply_high <= supply_request;
      pins.id_hv <= in_cycle && is_rd && (cur.op == fci_pkg::OP_ID_PIN);
      pins.ce_n <= !in_cycle;
      pins.oe_n <= !(state == fci_pkg::ST_STROBE && is_rd);
      pins.we_n <= !(state == fci_pkg::ST_STROBE && is_wr);
      pins.addr <= in_cycle ? wr_addr : pins.addr;
      data_out <= wr_byte;
      data_oe_n <= !(in_cycle && is_wr && state != fci_pkg::ST_SETUP);
    end
  end

  // ----------------------------------------------------------------------
  // data pin synchroniser
  // ----------------------------------------------------------------------
  fci_sync #(
    .W(`FCI_DATA_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .din(data_in),
    .dout(sync_data),
    .stable(sync_stable)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_wr_select;
    @(posedge ref_clk) disable iff (!reset_n)
    !pins.we_n |-> !pins.ce_n && pins.oe_n && !data_oe_n;
  endproperty
  a_wr_select: assert property (p_wr_select) else $error("strobe without select or data");

  property p_addr_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    $fell(pins.we_n) |=> $stable(pins.addr) [*1] ##1 $stable(pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved under strobe");

  property p_wr_supply;
    @(posedge ref_clk) disable iff (!reset_n)
    !pins.we_n |-> pins.supply_high;
  endproperty
  a_wr_supply: assert property (p_wr_supply) else $error("write with supply low");

  property p_erase_twice;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_PULSE && step.act == fci_pkg::ACT_ERASE_WAIT
      |-> last_wr == `FCI_CMD_ERASE && prev_wr == `FCI_CMD_ERASE;
  endproperty
  a_erase_twice: assert property (p_erase_twice) else $error("erase without two codes");

  property p_erase_addr;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_HOLD && is_wr && wr_byte == `FCI_CMD_ERASE_CHECK
      |-> pins.addr == cur.addr;
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase check lacks address");

  property p_prog_setup;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_PULSE && step.act == fci_pkg::ACT_PROG_WAIT
      |-> prev_wr == `FCI_CMD_PROGRAM && last_wr == cur.data;
  endproperty
  a_prog_setup: assert property (p_prog_setup) else $error("program without set-up");

  property p_prog_check;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_HOLD && is_wr && wr_byte == `FCI_CMD_PROGRAM_CHECK
      |-> prev_wr == `FCI_CMD_PROGRAM && $past(state, 5) != fci_pkg::ST_IDLE;
  endproperty
  a_prog_check: assert property (p_prog_check) else $error("check not after program");

  property p_reset_pair;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_FINISH && cur.op == fci_pkg::OP_RESET && !err
      |-> last_wr == `FCI_CMD_RESET && prev_wr == `FCI_CMD_RESET;
  endproperty
  a_reset_pair: assert property (p_reset_pair) else $error("reset not two all-ones");

  property p_pulse_min;
    @(posedge ref_clk) disable iff (!reset_n)
    state == fci_pkg::ST_PULSE && next_state != fci_pkg::ST_PULSE
      |-> cnt == pulse_need - 32'd1 && pins.we_n && pins.ce_n;
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pulse shorter than minimum");

endmodule // fci_host

`default_nettype wire

/* shared/fci_cfg.svh */
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH

// ----------------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------------
`define FCI_ADDR_W 15
`define FCI_DATA_W 8

// ----------------------------------------------------------------------
// command codes written into the device command latch
// ----------------------------------------------------------------------
`define FCI_CMD_READ 8'h00
`define FCI_CMD_IDENT 8'h90
`define FCI_CMD_ERASE 8'h20
`define FCI_CMD_ERASE_CHECK 8'ha0
`define FCI_CMD_PROGRAM 8'h40
`define FCI_CMD_PROGRAM_CHECK 8'hc0
`define FCI_CMD_RESET 8'hff

// ----------------------------------------------------------------------
// strobe timing, in ns, and derived cycle counts (rounded up)
// ----------------------------------------------------------------------
`define FCI_CLK_NS 50
`define FCI_SETUP_NS 50
`define FCI_WE_LOW_NS 100
`define FCI_ACCESS_NS 150
`define FCI_RECOVER_NS 50
`define FCI_SETUP_CYC ((`FCI_SETUP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WE_CYC ((`FCI_WE_LOW_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_ACCESS_CYC ((`FCI_ACCESS_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_RECOVER_CYC ((`FCI_RECOVER_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
// pin lag (1) plus three synchroniser stages
`define FCI_SYNC_CYC 4
// default minimum pulses, in us
`define FCI_PROG_PULSE_US 10
`define FCI_ERASE_PULSE_US 10000

`endif

/* shared/fci_pkg.sv */
`default_nettype none
`include "fci_cfg.svh"

package fci_pkg;

  // user operations
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_CMD = 3'b001,
    OP_ERASE = 3'b010,
    OP_PROGRAM = 3'b011,
    OP_RESET = 3'b100,
    OP_ID_PIN = 3'b101
  } fci_op_e;

  // action of one sequence step
  typedef enum logic [2:0] {
    ACT_NONE = 3'b000,
    ACT_WR = 3'b001,
    ACT_RD = 3'b010,
    ACT_PROG_WAIT = 3'b011,
    ACT_ERASE_WAIT = 3'b100
  } fci_act_e;

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_RECOVER = 3'b100,
    ST_PULSE = 3'b101,
    ST_FINISH = 3'b110
  } fci_state_e;

  // one step of a command sequence
  typedef struct packed {
    fci_act_e act;
    logic [`FCI_DATA_W-1:0] data;
    logic use_addr;
    logic use_data;
  } fci_step_s;

  // user request
  typedef struct packed {
    fci_op_e op;
    logic [`FCI_ADDR_W-1:0] addr;
    logic [`FCI_DATA_W-1:0] data;
  } fci_req_s;

  // control pins towards the memory
  typedef struct packed {
    logic supply_high;
    logic id_hv;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`FCI_ADDR_W-1:0] addr;
  } fci_pins_s;

endpackage

`default_nettype wire

/* rtl/fci_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; stable when stages two and three agree
module fci_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // raw and synchronised data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic stable
);

  logic [W-1:0] s1; // only read by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------------
  // stage chain
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign dout = s3;
  assign stable = (s2 == s3);

endmodule // fci_sync

`default_nettype wire

/* tb/fci_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fci_cfg.svh"

// ----------------------------------------------------------------------
// behavioural byte-wide flash, driven only through its pins
// ----------------------------------------------------------------------
module fci_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary identity value
  parameter logic [7:0] DEV_CODE = 8'h3c, // arbitrary identity value
  parameter int PROG_MIN_NS = 1000,
  parameter int ERASE_MIN_NS = 2000,
  parameter int STOP_NS = 50000
) (
  // control pins and data bus from the host
  input wire fci_pkg::fci_pins_s pins,
  input wire logic [`FCI_DATA_W-1:0] dq_in,
  // data back to the host, enable low while driving
  output logic [`FCI_DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  // set when a pulse ended before its minimum
  output logic short_pulse
);
  logic [7:0] mem [0:32767]; // array contents
  logic [7:0] cmd; // command latch
  logic [7:0] eff_cmd; // latch as seen by reads
  logic [14:0] wa; // address of last write
  logic [14:0] erase_check_address; // erase check address
  logic [14:0] program_target_address; // program address
  logic [7:0] program_byte; // program byte
  logic [1:0] phase; // 0 plain, 1 erase set-up, 2 program set-up
  logic ff_seen; // first all-ones write after a set-up
  logic busy; // pulse running
  logic prog; // running pulse is a program
  realtime t0; // pulse start

  // power-up contents and state
  initial
  begin
    for (int i = 0; i < 32768; i++) mem[i] = ~i[7:0];
    cmd = 8'h00;
    {phase, ff_seen, busy, prog, short_pulse} = '0;
    {wa, erase_check_address, program_target_address, program_byte} = '0;
    t0 = 0;
  end

  // end a running pulse; chip select plays no part
  task automatic finish_op();
    if (busy)
    begin
      busy = 0;
      if ($realtime - t0 < (prog ? PROG_MIN_NS : ERASE_MIN_NS)) short_pulse = 1;
      if (prog) mem[program_target_address] = mem[program_target_address] & program_byte;
      else for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    end
  endtask

  // one accepted write: stop any pulse, then decode
  task automatic write_cycle(input logic [7:0] d);
    finish_op();
    if (phase == 2'd2 && d != `FCI_CMD_RESET)
    begin
      {program_target_address, program_byte, prog, busy, phase} = {wa, d, 1'b1, 1'b1, 2'd0};
      t0 = $realtime;
    end
    else if (phase == 2'd1 && d == `FCI_CMD_ERASE)
    begin
      {prog, busy, phase} = {1'b0, 1'b1, 2'd0};
      t0 = $realtime;
    end
    else if (phase != 2'd0 && d == `FCI_CMD_RESET && !ff_seen) ff_seen = 1;
    else if (ff_seen && d == `FCI_CMD_RESET)
    begin
      {phase, ff_seen, cmd} = {2'd0, 1'b0, d};
    end
    else
    begin
      cmd = d;
      ff_seen = 0;
      phase = (d == `FCI_CMD_ERASE) ? 2'd1 : (d == `FCI_CMD_PROGRAM) ? 2'd2 : 2'd0;
      if (d == `FCI_CMD_ERASE_CHECK) erase_check_address = wa;
    end
  endtask

  // stop timer for overlong pulses
  always @(posedge busy)
  begin
    #(STOP_NS);
    if (busy && $realtime - t0 >= STOP_NS) finish_op();
  end

  // supply removed: latch back to read-memory
  always @(negedge pins.supply_high)
  begin
    {cmd, phase, ff_seen} = '0;
  end

  // address on falling strobe, data on rising strobe
  always @(negedge pins.we_n) if (!pins.ce_n) wa = pins.addr;
  always @(posedge pins.we_n) if (!pins.ce_n && pins.supply_high) write_cycle(dq_in);

  // read path
  assign eff_cmd = pins.supply_high ? cmd : `FCI_CMD_READ;
  assign dq_oe_n = !(!pins.ce_n && !pins.oe_n && pins.we_n);
  always @*
  begin
    if (pins.id_hv) dq_out = pins.addr[0] ? DEV_CODE : MFR_CODE;
    else if (eff_cmd == `FCI_CMD_IDENT) dq_out = pins.addr[0] ? DEV_CODE : MFR_CODE;
    else if (eff_cmd == `FCI_CMD_ERASE_CHECK) dq_out = mem[erase_check_address];
    else if (eff_cmd == `FCI_CMD_PROGRAM_CHECK) dq_out = mem[program_target_address];
    else dq_out = mem[pins.addr];
  end
endmodule // fci_flash_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fci_cfg.svh"

// ----------------------------------------------------------------------
// host controller against the flash model
// ----------------------------------------------------------------------
module testbench;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary identity value
  localparam logic [7:0] DEV = 8'h3c; // arbitrary identity value
  // one table row: request, supply, expected answer
  typedef struct packed {
    fci_pkg::fci_op_e op;
    logic [14:0] addr;
    logic [7:0] data;
    logic supply;
    logic chk_data;
    logic [7:0] exp_data;
    logic exp_err;
  } fci_row_s;

  logic ref_clk = 0; // 20 MHz
  logic reset_n = 0;
  logic req_valid = 0;
  fci_pkg::fci_req_s req = '0;
  logic supply_request = 0;
  wire logic req_ready;
  wire logic rsp_valid;
  wire logic [7:0] rsp_data;
  wire logic rsp_error;
  wire fci_pkg::fci_pins_s pins;
  wire logic [7:0] data_out;
  wire logic data_oe_n;
  wire logic [7:0] dev_q;
  wire logic dev_oe_n;
  wire logic short_pulse;
  wire logic [7:0] dq_bus; // resolved data pins
  logic [7:0] idle_pat = 8'ha5; // undriven bus: inverse of last driven byte
  logic ce_q = 1;
  int ce_falls = 0;
  int n_fail = 0;
  int compares = 0;
  fci_row_s rows [] = '{
    '{fci_pkg::OP_READ, 15'h0005, 8'h00, 1'b0, 1'b1, 8'hfa, 1'b0},
    '{fci_pkg::OP_ID_PIN, 15'h0000, 8'h00, 1'b0, 1'b1, MFR, 1'b0},
    '{fci_pkg::OP_ID_PIN, 15'h0001, 8'h00, 1'b0, 1'b1, DEV, 1'b0},
    '{fci_pkg::OP_CMD, 15'h0000, `FCI_CMD_IDENT, 1'b0, 1'b0, 8'h00, 1'b1},
    '{fci_pkg::OP_ERASE, 15'h0010, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1},
    '{fci_pkg::OP_READ, 15'h0001, 8'h00, 1'b1, 1'b1, 8'hfe, 1'b0},
    '{fci_pkg::OP_PROGRAM, 15'h0010, 8'h0f, 1'b1, 1'b1, 8'h0f, 1'b0},
    '{fci_pkg::OP_READ, 15'h0020, 8'h00, 1'b1, 1'b1, 8'h0f, 1'b0},
    '{fci_pkg::OP_CMD, 15'h0000, `FCI_CMD_READ, 1'b1, 1'b0, 8'h00, 1'b0},
    '{fci_pkg::OP_READ, 15'h0020, 8'h00, 1'b1, 1'b1, 8'hdf, 1'b0},
    '{fci_pkg::OP_CMD, 15'h0000, `FCI_CMD_IDENT, 1'b1, 1'b0, 8'h00, 1'b0},
    '{fci_pkg::OP_READ, 15'h0000, 8'h00, 1'b1, 1'b1, MFR, 1'b0},
    '{fci_pkg::OP_READ, 15'h0001, 8'h00, 1'b1, 1'b1, DEV, 1'b0},
    '{fci_pkg::OP_READ, 15'h0001, 8'h00, 1'b1, 1'b1, DEV, 1'b0},
    '{fci_pkg::OP_READ, 15'h0001, 8'h00, 1'b0, 1'b1, 8'hfe, 1'b0},
    '{fci_pkg::OP_CMD, 15'h0000, 8'h55, 1'b1, 1'b0, 8'h00, 1'b0},
    '{fci_pkg::OP_READ, 15'h0040, 8'h00, 1'b1, 1'b1, 8'hbf, 1'b0},
    '{fci_pkg::OP_CMD, 15'h0000, `FCI_CMD_PROGRAM, 1'b1, 1'b0, 8'h00, 1'b0},
    '{fci_pkg::OP_RESET, 15'h0000, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
    '{fci_pkg::OP_READ, 15'h0030, 8'h00, 1'b1, 1'b1, 8'hcf, 1'b0},
    '{fci_pkg::OP_ERASE, 15'h0010, 8'h00, 1'b1, 1'b1, 8'hff, 1'b0},
    '{fci_pkg::OP_READ, 15'h0077, 8'h00, 1'b1, 1'b1, 8'hff, 1'b0}
  };

  // clock
  always #25 ref_clk = ~ref_clk;

  // data pins: host, device, else a changing pattern
  assign dq_bus = !data_oe_n ? data_out : (!dev_oe_n ? dev_q : idle_pat);

  // released bus shows the inverse of what was last driven
  always @(dq_bus)
  begin
    if (!data_oe_n || !dev_oe_n) idle_pat = ~dq_bus;
  end

  fci_host #(.PROG_PULSE_US(1), .ERASE_PULSE_US(2)) fci_host_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .supply_request(supply_request), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .pins(pins), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(dq_bus)
  );

  fci_flash_model fci_flash_model_i (
    .pins(pins), .dq_in(dq_bus), .dq_out(dev_q), .dq_oe_n(dev_oe_n),
    .short_pulse(short_pulse)
  );

  // compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // pin monitor: select falls, no contention, no strobe overlap
  always @(posedge ref_clk)
  begin
    ce_q <= pins.ce_n;
    if (ce_q === 1'b1 && pins.ce_n === 1'b0) ce_falls <= ce_falls + 1;
    if (reset_n)
    begin
      chk("bus contention", {7'h0, !data_oe_n && !dev_oe_n}, 8'h00);
      chk("strobe overlap", {7'h0, !pins.we_n && !pins.oe_n}, 8'h00);
    end
  end

  // wait for the answer pulse, bounded
  task automatic await_rsp();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 3000);
    if (rsp_valid !== 1'b1)
    begin
      chk("answer timeout", 8'h01, 8'h00);
      finish_test();
    end
  endtask

  // one request through to its answer
  task automatic run_row(input fci_row_s r);
    int falls0;
    supply_request <= r.supply;
    repeat (3) @(posedge ref_clk);
    falls0 = ce_falls;
    req_valid <= 1'b1;
    req <= '{r.op, r.addr, r.data};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    await_rsp();
    chk("rsp_error", {7'h0, rsp_error}, {7'h0, r.exp_err});
    if (r.chk_data) chk("rsp_data", rsp_data, r.exp_data);
    if (r.exp_err) chk("refused select", 8'(ce_falls - falls0), 8'h00);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk("ce_n in reset", {7'h0, pins.ce_n}, 8'h01);
    chk("data_oe_n in reset", {7'h0, data_oe_n}, 8'h01);
    chk("req_ready in reset", {7'h0, req_ready}, 8'h01);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) run_row(rows[i]);
    // supply removed during a program pulse: check write refused
    req_valid <= 1'b1;
    req <= '{fci_pkg::OP_PROGRAM, 15'h7ffe, 8'h00};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (15) @(posedge ref_clk);
    supply_request <= 1'b0;
    await_rsp();
    chk("rsp_error supply drop", {7'h0, rsp_error}, 8'h01);
    // reset in mid-read
    req_valid <= 1'b1;
    req <= '{fci_pkg::OP_READ, 15'h0003, 8'h00};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("ce_n after abort", {7'h0, pins.ce_n}, 8'h01);
    chk("oe_n after abort", {7'h0, pins.oe_n}, 8'h01);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    run_row('{fci_pkg::OP_READ, 15'h7fff, 8'h00, 1'b1, 1'b1, 8'hff, 1'b0});
    chk("short pulse", {7'h0, short_pulse}, 8'h00);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
